// *** hw/prs_readout.sv ***
// Serial instruction decoder and readout of the pressure sensor module.
`timescale 1ns/10ps
`default_nettype none
module prs_readout (
  input  wire logic i_clk_sys,   // System clock, 100 MHz.
  input  wire logic i_rst_b,     // Asynchronous reset, active low.
  input  wire logic i_sclk,      // Serial clock from host.
  input  wire logic i_din,       // Serial data from host.
  input  wire logic i_mclk,      // Converter master clock.
  input  wire logic i_sd_bit,    // Modulator bitstream.
  output logic      o_dout,      // Serial data to host.
  output logic      o_bridge_on, // Sensor bridge power.
  output logic      o_temp_sel,  // Converter input is temperature.
  output logic      o_conv_busy  // Conversion running.
);
  import prs_pkg::*;

  logic [3:0]  lvl;
  logic [3:0]  rise;
  logic        sclk_rise;
  logic        din_s;
  logic        mclk_rise;
  logic        sd_s;
  logic        conv_busy;
  logic [15:0] conv_result;

  prs_state_t  state_r, state_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [3:0]  sel_r, sel_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [20:0] hist_r, hist_nxt;
  logic        dout_r, dout_nxt;
  logic        start_r, start_nxt;
  logic        abort_r, abort_nxt;
  logic        temp_r, temp_nxt;
  logic        rst_hit;
  logic        is_conv;
  logic        is_cal;

  prs_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_sd_bit, i_mclk, i_din, i_sclk}),
    .o_level   (lvl),
    .o_rise    (rise)
  );

  assign sclk_rise = rise[0];
  assign din_s     = lvl[1];
  assign mclk_rise = rise[2];
  assign sd_s      = lvl[3];

  prs_conv u_conv (
    .i_clk_sys   (i_clk_sys),
    .i_rst_b     (i_rst_b),
    .i_mclk_rise (mclk_rise),
    .i_sd_bit    (sd_s),
    .i_start     (start_r),
    .i_abort     (abort_r),
    .o_busy      (conv_busy),
    .o_bridge_on (o_bridge_on),
    .o_result    (conv_result)
  );

  function automatic logic [15:0] cal_word(input logic [3:0] sel);
    logic [15:0] w;
    w = 16'h0000;
    if (sel == SEL_CAL1) begin
      w = CAL_PROM[63:48];
    end else if (sel == SEL_CAL2) begin
      w = CAL_PROM[47:32];
    end else if (sel == SEL_CAL3) begin
      w = CAL_PROM[31:16];
    end else if (sel == SEL_CAL4) begin
      w = CAL_PROM[15:0];
    end
    return w;
  endfunction : cal_word

  assign is_conv = (sel_r == SEL_PRESS) || (sel_r == SEL_TEMP);
  assign is_cal  = (sel_r == SEL_CAL1) || (sel_r == SEL_CAL2) ||
                   (sel_r == SEL_CAL3) || (sel_r == SEL_CAL4);

  // The reset pattern is watched on every bit, whatever the protocol state.
  always_comb begin
    hist_nxt = hist_r;
    if (sclk_rise) begin
      hist_nxt = {hist_r[19:0], din_s};
    end
    rst_hit = sclk_rise && (hist_nxt == RESET_PATTERN);
    if (rst_hit) begin
      hist_nxt = 21'h00_0000;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sel_nxt   = sel_r;
    shift_nxt = shift_r;
    dout_nxt  = dout_r;
    temp_nxt  = temp_r;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    if (rst_hit) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 5'h00;
      dout_nxt  = 1'b0;
      abort_nxt = 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sclk_rise) begin
            dout_nxt = 1'b0;
            if (!din_s) begin
              cnt_nxt = 5'h00;
            end else if (cnt_r == 5'(START_LEN - 1)) begin
              cnt_nxt   = 5'h00;
              state_nxt = ST_SETUP;
            end else begin
              cnt_nxt = cnt_r + 5'h01;
            end
          end
        end
        ST_SETUP: begin
          if (sclk_rise) begin
            sel_nxt = {sel_r[2:0], din_s};
            if (cnt_r == 5'(SEL_LEN - 1)) begin
              cnt_nxt   = 5'h00;
              state_nxt = ST_STOP;
            end else begin
              cnt_nxt = cnt_r + 5'h01;
            end
          end
        end
        ST_STOP: begin
          // A high stop bit breaks the frame.
          if (sclk_rise) begin
            if (din_s) begin
              cnt_nxt   = 5'h00;
              state_nxt = ST_IDLE;
            end else if (cnt_r == 5'(STOP_LEN - 1)) begin
              cnt_nxt = 5'h00;
              if (is_conv) begin
                dout_nxt  = 1'b1;
                start_nxt = 1'b1;
                temp_nxt  = (sel_r == SEL_TEMP);
                state_nxt = ST_ACK;
              end else if (is_cal) begin
                shift_nxt = cal_word(sel_r);
                state_nxt = ST_READ;
              end else begin
                state_nxt = ST_IDLE;
              end
            end else begin
              cnt_nxt = cnt_r + 5'h01;
            end
          end
        end
        ST_ACK: begin
          if (sclk_rise) begin
            if (cnt_r == 5'(ACK_CLKS - 1)) begin
              cnt_nxt   = 5'h00;
              state_nxt = ST_CONV;
            end else begin
              cnt_nxt = cnt_r + 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (!conv_busy) begin
            dout_nxt  = 1'b0;
            shift_nxt = conv_result;
            state_nxt = ST_READ;
          end
        end
        ST_READ: begin
          if (sclk_rise) begin
            if (cnt_r != 5'h00) begin
              dout_nxt  = shift_r[15];
              shift_nxt = {shift_r[14:0], 1'b0};
            end
            // Back to idle after last clock.
            if (cnt_r == 5'(READ_CLKS - 1)) begin
              cnt_nxt   = 5'h00;
              state_nxt = ST_IDLE;
            end else begin
              cnt_nxt = cnt_r + 5'h01;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Output changes are registered on the detected rise, except the end-of-conversion drop in ST_CONV.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= 5'h00;
      sel_r   <= 4'h0;
      shift_r <= 16'h0000;
      hist_r  <= 21'h00_0000;
      dout_r  <= 1'b0;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      temp_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sel_r   <= sel_nxt;
      shift_r <= shift_nxt;
      hist_r  <= hist_nxt;
      dout_r  <= dout_nxt;
      start_r <= start_nxt;
      abort_r <= abort_nxt;
      temp_r  <= temp_nxt;
    end
  end

  assign o_dout      = dout_r;
  assign o_temp_sel  = temp_r;
  assign o_conv_busy = conv_busy;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_lead;
    state_r == ST_IDLE && cnt_r == 5'h02 && sclk_rise && din_s && !rst_hit;
  endsequence
  sequence s_stop_done;
    state_r == ST_STOP && cnt_r == 5'h02 && sclk_rise && !din_s && !rst_hit;
  endsequence

  capture_bit_a : assert property (sclk_rise && !rst_hit |=> hist_r[0] == $past(din_s))
    else $error("Input bit not captured on clock rise.");
  launch_edge_a : assert property (!sclk_rise && state_r != ST_CONV |=> $stable(dout_r))
    else $error("Output changed without a clock rise.");
  start_frame_a : assert property (s_lead |=> state_r == ST_SETUP)
    else $error("Lead-in not recognised.");
  stop_frame_a : assert property (state_r == ST_STOP && sclk_rise && din_s && !rst_hit |=> state_r == ST_IDLE)
    else $error("Broken stop field accepted.");
  select_width_a : assert property (state_r == ST_SETUP && cnt_r == 5'h03 && sclk_rise && !rst_hit
                                    |=> state_r == ST_STOP)
    else $error("Select field length wrong.");
  ack_rise_a : assert property (s_stop_done ##0 is_conv |=> $rose(dout_r) ##1 conv_busy)
    else $error("Conversion start not acknowledged.");
  conv_end_a : assert property (state_r == ST_CONV && !conv_busy && !rst_hit |=> !dout_r && state_r == ST_READ)
    else $error("Conversion end not signalled.");
  read_bit_a : assert property (state_r == ST_READ && cnt_r != 5'h00 && sclk_rise && !rst_hit
                                |=> dout_r == $past(shift_r[15]))
    else $error("Result bit not shifted out.");
  read_pause_a : assert property (state_r == ST_READ && !sclk_rise |=> $stable(shift_r) && $stable(cnt_r))
    else $error("Readout moved while clock held.");
  reset_seq_a : assert property (rst_hit |=> (state_r == ST_IDLE && cnt_r == 5'h00) ##1 !conv_busy)
    else $error("Reset pattern did not resynchronise.");
  cal_load_a : assert property (s_stop_done ##0 sel_r == SEL_CAL1 |=> shift_r == CAL_PROM[63:48])
    else $error("Wrong calibration word loaded.");
  idle_return_a : assert property (state_r == ST_READ && cnt_r == 5'h10 && sclk_rise && !rst_hit
                                   |=> state_r == ST_IDLE)
    else $error("Readout did not return to idle.");
endmodule : prs_readout
`default_nettype wire

// *** pkg/prs_pkg.sv ***
// Constants and types shared by the pressure sensor serial readout.
`default_nettype none
package prs_pkg;
  // Serial framing lengths in serial clocks.
  localparam int unsigned START_LEN  = 3;
  localparam int unsigned SEL_LEN    = 4;
  localparam int unsigned STOP_LEN   = 3;
  localparam int unsigned ACK_CLKS   = 2;
  localparam int unsigned READ_CLKS  = 17;
  localparam int unsigned RESET_LEN  = 21;
  localparam logic [20:0] RESET_PATTERN = 21'h15_5540;

  // Select codes of the four-bit setup field.
  localparam logic [3:0] SEL_PRESS = 4'hA;
  localparam logic [3:0] SEL_TEMP  = 4'h9;
  localparam logic [3:0] SEL_CAL1  = 4'h5;
  localparam logic [3:0] SEL_CAL2  = 4'h6;
  localparam logic [3:0] SEL_CAL3  = 4'h3;
  localparam logic [3:0] SEL_CAL4  = 4'hC;

  // Factory calibration store; the value is arbitrary.
  localparam logic [63:0] CAL_PROM = 64'h1357_2468_9BDF_ACE0;

  // Converter timing on the master clock.
  localparam int unsigned MCLK_HZ      = 32_768;
  localparam int unsigned BRIDGE_US    = 2_000;
  localparam int unsigned CONV_MS      = 35;
  localparam int unsigned BRIDGE_TICKS = BRIDGE_US * MCLK_HZ / 1_000_000;
  localparam int unsigned CONV_TICKS   = CONV_MS * MCLK_HZ / 1_000;
  localparam int unsigned BURSTS       = 5;
  localparam int unsigned SLOT_TICKS   = CONV_TICKS / BURSTS;
  localparam int unsigned BURST_ON     = BRIDGE_TICKS / BURSTS;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STOP, ST_ACK, ST_CONV, ST_READ} prs_state_t;
endpackage : prs_pkg
`default_nettype wire

// *** hw/prs_sync.sv ***
// Two-stage synchroniser with rising-edge detection for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module prs_sync (
  input  wire logic       i_clk_sys, // System clock.
  input  wire logic       i_rst_b,   // Asynchronous reset, active low.
  input  wire logic [3:0] i_async,   // Inputs from outside the domain.
  output logic      [3:0] o_level,   // Synchronised levels.
  output logic      [3:0] o_rise     // One-cycle rising-edge pulses.
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] last_r;

  // Only the second stage reads the first, so metastability never reaches logic.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
      last_r <= 4'h0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_rise  = sync_r & ~last_r;
endmodule : prs_sync
`default_nettype wire

// *** hw/prs_conv.sv ***
// Shared converter sequencer with duty-cycled sensor bridge power.
`timescale 1ns/10ps
`default_nettype none
module prs_conv (
  input  wire logic        i_clk_sys,   // System clock.
  input  wire logic        i_rst_b,     // Asynchronous reset, active low.
  input  wire logic        i_mclk_rise, // Master clock rising edge.
  input  wire logic        i_sd_bit,    // Modulator bitstream, synchronised.
  input  wire logic        i_start,     // Start pulse.
  input  wire logic        i_abort,     // Abort pulse.
  output logic             o_busy,      // Conversion running.
  output logic             o_bridge_on, // Bridge power enable.
  output logic      [15:0] o_result     // Last result.
);
  import prs_pkg::*;

  logic        busy_r, busy_nxt;
  logic        bridge_r, bridge_nxt;
  logic        done_r, done_nxt;
  logic [7:0]  tick_r, tick_nxt;
  logic [2:0]  slot_r, slot_nxt;
  logic [6:0]  on_r, on_nxt;
  logic [17:0] acc_r, acc_nxt;
  logic [15:0] res_r, res_nxt;

  always_comb begin
    busy_nxt = busy_r;
    tick_nxt = tick_r;
    slot_nxt = slot_r;
    on_nxt   = on_r;
    acc_nxt  = acc_r;
    res_nxt  = res_r;
    done_nxt = 1'b0;
    if (i_abort) begin
      busy_nxt = 1'b0;
    end else if (i_start && !busy_r) begin
      busy_nxt = 1'b1;
      tick_nxt = 8'h00;
      slot_nxt = 3'h0;
      on_nxt   = 7'h00;
      acc_nxt  = 18'h0_0000;
    end else if (busy_r) begin
      if (bridge_r && i_sd_bit) begin
        acc_nxt = acc_r + 18'h0_0001;
      end
      if (i_mclk_rise) begin
        if (bridge_r) begin
          on_nxt = on_r + 7'h01;
        end
        if (tick_r == 8'(SLOT_TICKS - 1)) begin
          tick_nxt = 8'h00;
          if (slot_r == 3'(BURSTS - 1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            res_nxt  = acc_nxt[17:2];
          end else begin
            slot_nxt = slot_r + 3'h1;
          end
        end else begin
          tick_nxt = tick_r + 8'h01;
        end
      end
    end
    bridge_nxt = busy_nxt && (tick_nxt < 8'(BURST_ON));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_r   <= 1'b0;
      bridge_r <= 1'b0;
      done_r   <= 1'b0;
      tick_r   <= 8'h00;
      slot_r   <= 3'h0;
      on_r     <= 7'h00;
      acc_r    <= 18'h0_0000;
      res_r    <= 16'h0000;
    end else begin
      busy_r   <= busy_nxt;
      bridge_r <= bridge_nxt;
      done_r   <= done_nxt;
      tick_r   <= tick_nxt;
      slot_r   <= slot_nxt;
      on_r     <= on_nxt;
      acc_r    <= acc_nxt;
      res_r    <= res_nxt;
    end
  end

  assign o_busy      = busy_r;
  assign o_bridge_on = bridge_r;
  assign o_result    = res_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  bridge_budget_a : assert property (on_r <= 7'(BRIDGE_TICKS))
    else $error("Bridge on-time exceeds budget.");
  bridge_idle_a : assert property (!busy_r |-> !bridge_r)
    else $error("Bridge powered while idle.");
  conv_done_a : assert property ($fell(busy_r) && !$past(i_abort) |-> done_r)
    else $error("Conversion ended without a result.");
endmodule : prs_conv
`default_nettype wire

// *** verification/prs_host_model.sv ***
// Host-side model that clocks the serial link and the converter master clock.
`timescale 1ns/10ps
`default_nettype none
module prs_host_model (
  input  wire logic i_clk_sys, // System clock used for pacing.
  input  wire logic i_dout,    // Serial data from the device.
  output logic      o_sclk,    // Serial clock.
  output logic      o_din,     // Serial data to the device.
  output logic      o_mclk     // Converter master clock.
);
  import prs_pkg::*;
  localparam int HALF      = 8;
  localparam int MCLK_HALF = 4;

  initial begin
    o_sclk = 1'b0;
    o_din  = 1'b0;
    o_mclk = 1'b0;
  end

  initial begin
    forever begin
      tick(MCLK_HALF);
      o_mclk = ~o_mclk;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  // Host clocks, changes and samples on fall.
  task automatic pulse(input logic d, output logic q);
    o_din = d;
    tick(HALF);
    o_sclk = 1'b1;
    tick(HALF);
    q = i_dout;
    o_sclk = 1'b0;
  endtask : pulse

  task automatic frame(input logic [3:0] sel, output logic q);
    logic [9:0] f;
    f = {3'b111, sel, 3'b000};
    for (int i = 9; i >= 0; i--) begin
      pulse(f[i], q);
    end
  endtask : frame

  // Two clocks after acknowledge, then clock held low.
  task automatic start_conv(input logic [3:0] sel, output logic ack);
    logic q;
    frame(sel, ack);
    pulse(1'b0, q);
    pulse(1'b0, q);
  endtask : start_conv

  // Bounded wait for the end-of-conversion edge.
  task automatic wait_end(output logic done);
    for (int n = 0; n < 12000 && i_dout === 1'b1; n++) begin
      tick(1);
    end
    done = (i_dout === 1'b0);
  endtask : wait_end

  // Dummy clock then sixteen bits, optional pause.
  task automatic read16(input int pause_at, input int pause_len, output logic [15:0] w);
    logic q;
    for (int k = 0; k <= 16; k++) begin
      pulse(1'b0, q);
      if (k > 0) begin
        w[16-k] = q;
      end
      if (k == pause_at) begin
        tick(pause_len);
      end
    end
  endtask : read16

  task automatic reset_seq();
    logic q;
    for (int i = 20; i >= 0; i--) begin
      pulse(RESET_PATTERN[i], q);
    end
  endtask : reset_seq
endmodule : prs_host_model
`default_nettype wire

// *** verification/prs_readout_test.sv ***
// Self-checking bench for the pressure sensor serial readout.
`timescale 1ns/10ps
`default_nettype none
module prs_readout_test;
  import prs_pkg::*;
  localparam int MCLK_PER = 8;
  logic        clk_sys, rst_b, sclk, din, mclk, sd_bit;
  logic        dout, bridge_on, temp_sel, conv_busy;
  logic        ack, done, lvl;
  logic        bridge_q = 1'b0;
  logic [3:0]  bad;
  logic [15:0] word;
  logic [3:0]  cal_sel [4] = '{SEL_CAL1, SEL_CAL2, SEL_CAL3, SEL_CAL4};
  integer      seed = 70996;
  int          failures = 0;
  int          check_count = 0;
  int          on_cycles = 0;
  int          bursts = 0;

  prs_readout dut_u (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_sclk(sclk), .i_din(din), .i_mclk(mclk),
    .i_sd_bit(sd_bit), .o_dout(dout), .o_bridge_on(bridge_on), .o_temp_sel(temp_sel),
    .o_conv_busy(conv_busy)
  );

  prs_host_model host_u (
    .i_clk_sys(clk_sys), .i_dout(dout), .o_sclk(sclk), .o_din(din), .o_mclk(mclk)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Bridge on-time and burst count, measured at the pin.
  always @(posedge clk_sys) begin
    bridge_q <= bridge_on;
    if (bridge_on === 1'b1) on_cycles <= on_cycles + 1;
    if (bridge_on === 1'b1 && bridge_q !== 1'b1) bursts <= bursts + 1;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] cal_word(input int k);
    return CAL_PROM[63-16*k -: 16];
  endfunction : cal_word

  // Result counts ones at system rate while the bridge is on, divided by four.
  function automatic logic [15:0] exp_result(input logic l);
    return l ? 16'(BURSTS * BURST_ON * MCLK_PER / 4) : 16'h0000;
  endfunction : exp_result

  task automatic cal_test(input int k, input int pause);
    host_u.frame(cal_sel[k], ack);
    host_u.read16(pause, 40, word);
    check("calibration word", word, cal_word(k));
  endtask : cal_test

  task automatic conv_test(input logic [3:0] sel, input logic l, input int pause);
    sd_bit = l;
    on_cycles = 0;
    bursts = 0;
    // The first burst only spans whole master ticks when the last stop clock reaches the
    // design one system cycle before a master clock rise, so the frame is lined up here.
    @(posedge mclk);
    host_u.tick(MCLK_PER - 1);
    host_u.start_conv(sel, ack);
    check("acknowledge", {15'h0000, ack}, 16'h0001);
    check("temperature select", {15'h0000, temp_sel}, {15'h0000, sel == SEL_TEMP});
    check("busy", {15'h0000, conv_busy}, 16'h0001);
    host_u.wait_end(done);
    check("conversion end", {15'h0000, done}, 16'h0001);
    check("bridge bursts", bursts[15:0], 16'(BURSTS));
    check("bridge on time", on_cycles[15:0], 16'(BURSTS * BURST_ON * MCLK_PER));
    check("bridge off", {15'h0000, bridge_on}, 16'h0000);
    host_u.read16(pause, 40, word);
    check("result", word, exp_result(l));
  endtask : conv_test

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rst_b  = 1'b0;
    sd_bit = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    host_u.tick(4);
    check("idle output", {15'h0000, dout}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      cal_test(k, 99);
    end
    $display("test calibration words done");
    // Random words with the serial clock held low at a random point.
    for (int n = 0; n < 6; n++) begin
      cal_test($unsigned($random(seed)) % 4, $unsigned($random(seed)) % 17);
    end
    $display("test paused readout done");
    conv_test(SEL_PRESS, 1'b1, 99);
    conv_test(SEL_TEMP, 1'b0, 5);
    lvl = 1'($random(seed));
    conv_test(lvl ? SEL_TEMP : SEL_PRESS, ~lvl, $unsigned($random(seed)) % 17);
    $display("test conversions done");
    do begin
      bad = 4'($random(seed));
    end while (bad inside {SEL_PRESS, SEL_TEMP, SEL_CAL1, SEL_CAL2, SEL_CAL3, SEL_CAL4});
    host_u.frame(bad, ack);
    check("no acknowledge", {15'h0000, ack}, 16'h0000);
    cal_test(1, 99);
    $display("test unknown select done");
    // Pattern sent during a running conversion must abort it.
    sd_bit = 1'b1;
    host_u.start_conv(SEL_PRESS, ack);
    host_u.tick(300);
    host_u.reset_seq();
    host_u.tick(8);
    check("busy after reset", {15'h0000, conv_busy}, 16'h0000);
    check("output after reset", {15'h0000, dout}, 16'h0000);
    cal_test(3, 99);
    $display("test reset pattern done");
    stop_test();
  end
endmodule : prs_readout_test
`default_nettype wire
